//--- dppc_pkg.sv
/*
  constants for the downstream port power control block: pin levels,
  phase timing and the sequencer state encoding.
  assumes a 50 MHz core clock and pull-ups on every control pin.
*/
// Summary of operation
// [RULE1] strap levels captured at power-on and at reset release, then held
// [RULE2] output phase drives port pin high to power that port, four ports
// [RULE3] input phase reads port pin level as overcurrent for that port
// [RULE4] gang strap sampled high selects gang mode, low selects per-port
// [RULE5] in gang mode the gang strap pin is the shared power pin
// [RULE6] while external reset is low the block stays in reset
// [RULE7] gang overcurrent flags all ports and removes all port power
package dppc_pkg;
  // ==========================================================
  // clock and timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int DRIVE_NS      = 1000;
  localparam int SENSE_NS      = 200;
  localparam int DRIVE_CYC     = (DRIVE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SENSE_CYC     = (SENSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W         = 8;

  // ==========================================================
  // pin levels
  localparam logic OVC_LEVEL   = 1'b0;
  localparam logic PWR_ON      = 1'b1;
  localparam logic GANG_LEVEL  = 1'b1;
  localparam int   NUM_PORTS   = 4;

  // ==========================================================
  // sequencer states, gray along capture -> drive -> sense
  typedef enum logic [1:0] {
    ST_CAPTURE = 2'h0,
    ST_DRIVE   = 2'h1,
    ST_SENSE   = 2'h3
  } dppc_state_t;
endpackage : dppc_pkg

//--- dppc_port_power.sv
/*
  downstream port power control: one two-way pin per port, driven as a
  power enable and released to read overcurrent, plus the gang strap pin.
  assumes synchronous pin inputs, pull-ups on all pins and a reset that
  also covers power-on.
*/
`timescale 1ns/1ns
module dppc_port_power #(
  parameter int NPORT = dppc_pkg::NUM_PORTS
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             reset_n,
  // hub side
  input  wire logic [NPORT-1:0] power_req,
  input  wire logic [NPORT-1:0] ovc_clear,
  output logic      [NPORT-1:0] ovc_flag,
  output logic                  gang_mode,
  // per-port control pins, bit 0 is port 1
  input  wire logic [NPORT-1:0] port_power_ovc_in,
  output logic      [NPORT-1:0] port_power_ovc_out,
  output logic      [NPORT-1:0] port_power_ovc_oe,
  // gang strap and shared power pin
  input  wire logic             shared_port_power_strap_in,
  output logic                  shared_port_power_strap_out,
  output logic                  shared_port_power_strap_oe
);

  // ==========================================================
  // state
  dppc_pkg::dppc_state_t         state;
  dppc_pkg::dppc_state_t         next_state;
  logic [dppc_pkg::CNT_W-1:0]    cnt;
  logic [dppc_pkg::CNT_W-1:0]    next_cnt;
  logic                          next_gang_mode;
  logic [NPORT-1:0]              next_ovc_flag;
  logic [NPORT-1:0]              next_port_out;
  logic [NPORT-1:0]              next_port_oe;
  logic                          next_shared_out;
  logic                          next_shared_oe;
  logic [NPORT-1:0]              want;
  logic [NPORT-1:0]              hit;
  logic                          gang_hit;
  logic                          sample;

  localparam logic [dppc_pkg::CNT_W-1:0] DRIVE_LAST =
    dppc_pkg::CNT_W'(dppc_pkg::DRIVE_CYC - 1);
  localparam logic [dppc_pkg::CNT_W-1:0] SENSE_LAST =
    dppc_pkg::CNT_W'(dppc_pkg::SENSE_CYC - 1);

  // ==========================================================
  // sense decode
  assign want     = power_req & ~ovc_flag;
  assign sample   = (state == dppc_pkg::ST_SENSE) && (cnt == SENSE_LAST);
  // sample only at the end of the release window so the pull-up has settled
  genvar g;
  generate
    for (g = 0; g < NPORT; g++)
    begin : g_hit
      assign hit[g] = sample && !gang_mode && port_power_ovc_out[g]
                      && (port_power_ovc_in[g] == dppc_pkg::OVC_LEVEL); // [RULE3]
    end
  endgenerate
  assign gang_hit = sample && gang_mode && shared_port_power_strap_out
                    && (shared_port_power_strap_in == dppc_pkg::OVC_LEVEL); // [RULE7]

  // ==========================================================
  // next values
  always_comb
  begin
    next_state      = state;
    next_cnt        = cnt;
    next_gang_mode  = gang_mode;
    next_port_out   = port_power_ovc_out;
    next_port_oe    = port_power_ovc_oe;
    next_shared_out = shared_port_power_strap_out;
    next_shared_oe  = shared_port_power_strap_oe;
    // set beats clear so a fault in the clearing cycle is kept
    next_ovc_flag   = (ovc_flag & ~ovc_clear) | hit | {NPORT{gang_hit}}; // [RULE3] [RULE7]
    case (state)
      dppc_pkg::ST_CAPTURE:
      begin
        // first edge after reset release; pins are all released here
        next_gang_mode = (shared_port_power_strap_in == dppc_pkg::GANG_LEVEL); // [RULE1] [RULE4]
        next_cnt       = '0;
        next_state     = dppc_pkg::ST_DRIVE;
      end
      dppc_pkg::ST_DRIVE:
      begin
        if (gang_mode)
        begin
          // any flagged port drops the shared supply for everyone
          next_shared_out = (|power_req) && !(|ovc_flag); // [RULE5] [RULE7]
          next_shared_oe  = 1'b1; // [RULE5]
          next_port_out   = '0;
          next_port_oe    = '0;
        end
        else
        begin
          next_port_out   = want; // [RULE2]
          next_port_oe    = {NPORT{1'b1}}; // [RULE2]
          next_shared_out = 1'b0;
          next_shared_oe  = 1'b0;
        end
        next_cnt = cnt + 1'b1;
        if (cnt == DRIVE_LAST)
        begin
          next_cnt   = '0;
          next_state = dppc_pkg::ST_SENSE;
        end
      end
      dppc_pkg::ST_SENSE:
      begin
        // release keeps enable high through the pull-up; an off port may see a
        // short high pulse, a trade for one pin doing both jobs
        next_port_oe   = '0; // [RULE3]
        next_shared_oe = 1'b0;
        next_cnt       = cnt + 1'b1;
        if (cnt == SENSE_LAST)
        begin
          next_cnt   = '0;
          next_state = dppc_pkg::ST_DRIVE;
        end
      end
      default:
      begin
        next_state = dppc_pkg::ST_CAPTURE;
        next_cnt   = '0;
      end
    endcase
  end

  // ==========================================================
  // registers
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      // held in reset with every pin released while reset_n is low
      state                       <= dppc_pkg::ST_CAPTURE; // [RULE6]
      cnt                         <= '0;
      gang_mode                   <= 1'b0;
      ovc_flag                    <= '0;
      port_power_ovc_out          <= '0;
      port_power_ovc_oe           <= '0; // [RULE6]
      shared_port_power_strap_out <= 1'b0;
      shared_port_power_strap_oe  <= 1'b0;
    end
    else
    begin
      state                       <= next_state;
      cnt                         <= next_cnt;
      gang_mode                   <= next_gang_mode;
      ovc_flag                    <= next_ovc_flag;
      port_power_ovc_out          <= next_port_out;
      port_power_ovc_oe           <= next_port_oe;
      shared_port_power_strap_out <= next_shared_out;
      shared_port_power_strap_oe  <= next_shared_oe;
    end
  end

  // ==========================================================
  // checks
  property p_strap_held;
    @(posedge core_clk) disable iff (!reset_n)
    (state != dppc_pkg::ST_CAPTURE && $past(state) != dppc_pkg::ST_CAPTURE)
      |-> $stable(gang_mode);
  endproperty
  a_strap_held: assert property (p_strap_held) else $error("strap changed after capture"); // [RULE1]

  property p_drive_high;
    @(posedge core_clk) disable iff (!reset_n)
    (state == dppc_pkg::ST_DRIVE && $past(state) == dppc_pkg::ST_DRIVE && !gang_mode)
      |-> (port_power_ovc_oe == {NPORT{1'b1}}) && (port_power_ovc_out == $past(want));
  endproperty
  a_drive_high: assert property (p_drive_high) else $error("port enable not driven"); // [RULE2]

  property p_ovc_sense;
    @(posedge core_clk) disable iff (!reset_n)
    (hit != '0) |=> ((ovc_flag & $past(hit)) == $past(hit))
      ##1 ((port_power_ovc_out & $past(hit, 2)) == '0);
  endproperty
  a_ovc_sense: assert property (p_ovc_sense) else $error("overcurrent not flagged"); // [RULE3]

  // a driven pin would read back its own level and hide the monitor
  property p_sense_released;
    @(posedge core_clk) disable iff (!reset_n)
    sample |-> (port_power_ovc_oe == '0) && !shared_port_power_strap_oe;
  endproperty
  a_sense_released: assert property (p_sense_released) else $error("pin driven while sensed"); // [RULE3]

  property p_gang_select;
    @(posedge core_clk) disable iff (!reset_n)
    (state == dppc_pkg::ST_CAPTURE)
      |=> (gang_mode == ($past(shared_port_power_strap_in) == dppc_pkg::GANG_LEVEL));
  endproperty
  a_gang_select: assert property (p_gang_select) else $error("gang mode wrong"); // [RULE4]

  property p_gang_pin;
    @(posedge core_clk) disable iff (!reset_n)
    (gang_mode && state == dppc_pkg::ST_DRIVE && $past(state) == dppc_pkg::ST_DRIVE)
      |-> shared_port_power_strap_oe && (port_power_ovc_oe == '0);
  endproperty
  a_gang_pin: assert property (p_gang_pin) else $error("shared pin not in use"); // [RULE5]

  property p_reset_hold;
    @(posedge core_clk) disable iff (!reset_n)
    $rose(reset_n) |-> (state == dppc_pkg::ST_CAPTURE) && (port_power_ovc_oe == '0)
      && !shared_port_power_strap_oe;
  endproperty
  a_reset_hold: assert property (p_reset_hold) else $error("not in reset state"); // [RULE6]

  property p_gang_ovc;
    @(posedge core_clk) disable iff (!reset_n)
    gang_hit |=> (ovc_flag == {NPORT{1'b1}}) ##[1:20] !shared_port_power_strap_out;
  endproperty
  a_gang_ovc: assert property (p_gang_ovc) else $error("gang fault kept power"); // [RULE7]

  c_port_fault: cover property (@(posedge core_clk) disable iff (!reset_n) hit != '0);
  c_gang_fault: cover property (@(posedge core_clk) disable iff (!reset_n) gang_hit);
  c_gang_power: cover property (@(posedge core_clk) disable iff (!reset_n)
                                gang_mode && shared_port_power_strap_out);
  c_clear_set:  cover property (@(posedge core_clk) disable iff (!reset_n)
                                (hit & ovc_clear) != '0);
endmodule : dppc_port_power

//--- dppc_switch_model.sv
/*
  partner model: external port power switches and current monitors.
  assumes pull-ups on every pin and a block that releases a pin by dropping oe.
*/
`timescale 1ns/1ns
module dppc_switch_model (
  // block side
  input  wire logic [3:0] port_out,
  input  wire logic [3:0] port_oe,
  input  wire logic       shared_out,
  input  wire logic       shared_oe,
  // test control
  input  wire logic [3:0] fault,
  input  wire logic       shared_low,
  // pin levels
  output logic      [3:0] port_pin,
  output logic            shared_pin
);
  // ==========================================================
  // released pins idle high, monitor pulls low on a fault
  assign port_pin   = (port_oe & port_out) | (~port_oe & ~fault);
  assign shared_pin = shared_oe ? shared_out : ~shared_low;
endmodule : dppc_switch_model

//--- tb_downstream_port_power_control.sv
/*
  self-checking bench for dppc_port_power with random port requests.
  assumes the switch model is compiled first and a 50 MHz core clock.
*/
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module tb_downstream_port_power_control;
  logic       core_clk  = 1'b0;
  logic       reset_n   = 1'b0;
  logic [3:0] power_req = 4'h0;
  logic [3:0] ovc_clear = 4'h0;
  logic [3:0] fault     = 4'h0;
  logic       s_low     = 1'b0;
  logic [3:0] ovc_flag, p_out, p_oe, p_in;
  logic       gang_mode, s_in, s_out, s_oe;
  int         num_errors = 0;
  int         n_compared = 0;
  int         seed       = 32'h8985;
  always #10 core_clk = ~core_clk;
  dppc_port_power u_dppc_port_power (.core_clk(core_clk), .reset_n(reset_n),
    .power_req(power_req), .ovc_clear(ovc_clear), .ovc_flag(ovc_flag),
    .gang_mode(gang_mode), .port_power_ovc_in(p_in), .port_power_ovc_out(p_out),
    .port_power_ovc_oe(p_oe), .shared_port_power_strap_in(s_in),
    .shared_port_power_strap_out(s_out), .shared_port_power_strap_oe(s_oe));
  dppc_switch_model u_dppc_switch_model (.port_out(p_out), .port_oe(p_oe),
    .shared_out(s_out), .shared_oe(s_oe), .fault(fault), .shared_low(s_low),
    .port_pin(p_in), .shared_pin(s_in));
  // ==========================================================
  // helpers
  function automatic logic [3:0] exp_out(input logic [3:0] q, input logic [3:0] f);
    return q & ~f;
  endfunction : exp_out
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : test_done
  task automatic rst(input logic lo);
    @(negedge core_clk);
    reset_n = 1'b0;
    s_low   = lo;
    repeat (3) @(negedge core_clk);
    `CHK("oe in reset", 5'h00, {p_oe, s_oe})
    `CHK("flag in reset", 4'h0, ovc_flag)
    reset_n = 1'b1;
  endtask : rst
  // wait for drive (1) or sense (0); bounded since the drive phase is 50 cycles and the sense phase 10
  task automatic ph(input logic v);
    int i;
    i = 0;
    while (((gang_mode ? s_oe : p_oe[0]) !== v) && i < 200)
    begin
      @(negedge core_clk);
      i++;
    end
    if (i >= 200)
    begin
      num_errors++;
      $display("CHECK FAILED phase exp %h got timeout", v);
    end
  endtask : ph
  // ==========================================================
  // tests
  initial
  begin
    rst(1'b1);
    ph(1'b1);
    s_low = 1'b0;
    @(negedge core_clk);
    `CHK("gang held low", 1'b0, gang_mode)
    repeat (5)
    begin
      power_req = 4'($random(seed));
      @(negedge core_clk);
      `CHK("port out", exp_out(power_req, 4'h0), p_out)
      `CHK("port oe", 4'hf, p_oe)
    end
    $display("test per-port drive done");
    // port 4 is off so its fault is ignored; a clear meets the set at the sample edge
    power_req = 4'h7;
    fault     = 4'hc;
    ph(1'b0);
    repeat (8) @(negedge core_clk);
    ovc_clear = 4'h4;
    @(negedge core_clk);
    ovc_clear = 4'h0;
    ph(1'b1);
    fault = 4'h0;
    repeat (2) @(negedge core_clk);
    `CHK("ovc flag", 4'h4, ovc_flag)
    `CHK("faulted out", exp_out(4'h7, 4'h4), p_out)
    ovc_clear = 4'h4;
    @(negedge core_clk);
    ovc_clear = 4'h0;
    @(negedge core_clk);
    `CHK("flag cleared", 4'h0, ovc_flag)
    $display("test overcurrent done");
    rst(1'b0);
    ph(1'b1);
    `CHK("gang set", 1'b1, gang_mode)
    repeat (4)
    begin
      power_req = 4'($random(seed));
      @(negedge core_clk);
      `CHK("shared out", |power_req, s_out)
      `CHK("port pins off", 5'h01, {p_oe, s_oe})
    end
    power_req = 4'h1;
    s_low     = 1'b1;
    ph(1'b0);
    ph(1'b1);
    s_low = 1'b0;
    repeat (2) @(negedge core_clk);
    `CHK("gang flags", 4'hf, ovc_flag)
    `CHK("gang power off", 1'b0, s_out)
    $display("test gang mode done");
    test_done();
  end
  initial
  begin
    #100000;
    num_errors++;
    test_done();
  end
endmodule : tb_downstream_port_power_control
